// ===== tmd_bench.sv
// Self-checking bench for the divider enable bank and test-mode control.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
`include "tmd_map.svh"

module tmd_bench;
	logic mclk, rst, scl, hl, tsel, tmode, dout, oe, cpu, pan, oen, sel, tma;
	wire sda = ~(oe | hl);
	int bad_count = 0;
	int samples_checked = 0;
	logic [7:0] rows [8][4] = '{'{8'h29, 8'h03, 8'h03, 8'h03}, '{8'h29, 8'h02, 8'h02, 8'h02},
		'{8'h29, 8'h01, 8'h01, 8'h01}, '{8'h29, 8'hfc, 8'h00, 8'h00}, '{8'h10, 8'hff, 8'h00, 8'h00},
		'{8'h28, 8'hff, 8'h00, 8'h00}, '{8'h29, 8'hff, 8'h03, 8'h03}, '{8'h10, 8'h00, 8'h00, 8'h03}};
	logic [7:0] v;
	logic [8:0] r9;

	tmd_top DUT (.mclk(mclk), .rst(rst), .smb_clk(scl), .smb_data_in(sda), .smb_data_out(dout),
		.smb_data_oe(oe), .test_select_pin(tsel), .test_mode_pin(tmode), .cpu_divider_program_enable(cpu),
		.panel_divider_program_enable(pan), .clk_out_enable(oen), .clk_out_ref_div_sel(sel),
		.test_mode_active(tma));
	tmd_host HOST (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(hl));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic send(input logic [7:0] b);
		logic [8:0] r;
		HOST.xfer({b, 1'b1}, r);
		chk({7'h00, r[0]}, 8'h00);
	endtask : send

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		HOST.start;
		send({`TMD_DEV_ADDR, 1'b0});
		send(a);
		send(d);
		HOST.stop;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] r;
		HOST.start;
		send({`TMD_DEV_ADDR, 1'b0});
		send(a);
		HOST.start;
		send({`TMD_DEV_ADDR, 1'b1});
		HOST.xfer(9'h1ff, r);
		d = r[8:1];
		HOST.stop;
	endtask : rd

	// Reset stands in for a power cycle; the strap is set before release.
	task automatic rst_to(input logic s);
		tsel = s;
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (8) @(negedge mclk);
	endtask : rst_to

	task automatic pin(input logic m, input logic [7:0] e);
		tmode = m;
		repeat (6) @(negedge mclk);
		chk({5'h00, tma, oen, sel}, e);
	endtask : pin

	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	initial begin
		rst = 1'b1;
		tmode = 1'b0;
		rst_to(1'b0);
		chk({3'h0, tma, oen, sel, cpu, pan}, 8'h08);
		chk({7'h00, dout}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], v);
			chk(v, rows[i][2]);
			chk({6'h00, cpu, pan}, rows[i][3]);
		end
		// A foreign address must go unanswered and leave the enables alone.
		HOST.start;
		HOST.xfer({`TMD_DEV_ADDR ^ 7'h01, 2'b01}, r9);
		chk({7'h00, r9[0]}, 8'h01);
		HOST.stop;
		chk({6'h00, cpu, pan}, 8'h03);
		// Two-byte read across the reserved tail into the enable byte.
		HOST.start;
		send({`TMD_DEV_ADDR, 1'b0});
		send(8'h28);
		HOST.start;
		send({`TMD_DEV_ADDR, 1'b1});
		HOST.xfer(9'h1fe, r9);
		chk(r9[8:1], 8'h00);
		HOST.xfer(9'h1ff, r9);
		chk(r9[8:1], 8'h03);
		HOST.stop;
		pin(1'b1, 8'h02);
		pin(1'b0, 8'h02);
		rst_to(1'b1);
		pin(1'b0, 8'h04);
		pin(1'b1, 8'h07);
		tsel = 1'b0;
		pin(1'b0, 8'h04);
		wr(8'h29, 8'h00);
		pin(1'b1, 8'h07);
		rst_to(1'b0);
		pin(1'b1, 8'h02);
		final_report;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		final_report;
	end
endmodule : tmd_bench

`default_nettype wire

// ===== tmd_host.sv
// Serial bus host model that drives the management bus of the bank.
// Assumes a pull-up on the data line, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none

module tmd_host (
	// Clock and bus pins
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Each bus phase lasts 8 system cycles, above the 5 the slave needs.
	task automatic hp;
		repeat (8) @(negedge mclk);
	endtask : hp

	task automatic start;
		sda_low = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		sda_low = 1'b1;
		hp;
		scl = 1'b0;
		hp;
	endtask : start

	task automatic stop;
		sda_low = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		sda_low = 1'b0;
		hp;
	endtask : stop

	// Eight data bits then the acknowledge slot; a 1 releases the line.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_low = ~tx[i];
			hp;
			scl = 1'b1;
			hp;
			rx[i] = sda;
			scl = 1'b0;
			// Data waits past the clock fall so no false start is seen.
			repeat (2) @(negedge mclk);
		end
	endtask : xfer
endmodule : tmd_host

`default_nettype wire

// ===== tmd_map.svh
// Constants for the divider program-enable bank and its test-mode control.
// Assumes inclusion by bare name from the package, the top module and the bench.
`ifndef TMD_MAP_SVH
`define TMD_MAP_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define TMD_RSVD_FIRST 8'h10
`define TMD_RSVD_LAST 8'h28
`define TMD_REG_PROG_EN 8'h29
`define TMD_PROG_EN_RESET 8'h00
`define TMD_BIT_CPU_EN 1
`define TMD_BIT_PANEL_EN 0
`define TMD_RSVD_BITS 6'h00
`define TMD_READ_ZERO 8'h00

// -----------------------------------------------------------------------------
// Serial bus and timing
// -----------------------------------------------------------------------------
// Arbitrary slave address, not tied to any real part.
`define TMD_DEV_ADDR 7'h2a
`define TMD_BITS_PER_BYTE 4'h8
`define TMD_LAST_TX_BIT 4'h7
`define TMD_SETTLE_CYC 2'h2

`endif

// ===== tmd_pkg.sv
// Types shared by the divider program-enable bank.
// Assumes tmd_map.svh sits in the same folder.
`include "tmd_map.svh"

package tmd_pkg;
	typedef enum logic [2:0] {
		TMD_ST_IDLE,
		TMD_ST_ADDR,
		TMD_ST_CMD,
		TMD_ST_WDATA,
		TMD_ST_ACK,
		TMD_ST_TX,
		TMD_ST_RACK
	} tmd_state_t;
endpackage : tmd_pkg

// ===== tmd_reg_if.sv
// Register access carrier between the serial engine and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface tmd_reg_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	logic cpu_en;
	logic panel_en;

	modport engine (output addr, output wdata, output we, input rdata, input cpu_en, input panel_en);
	modport bank (input addr, input wdata, input we, output rdata, output cpu_en, output panel_en);
endinterface : tmd_reg_if

`default_nettype wire

// ===== tmd_regs.sv
// Register bank holding the two feedback-divider program-enable bits.
// Assumes one-cycle write strobes from the serial engine on the same clock.
`timescale 1ns/1ps
`default_nettype none

module tmd_regs import tmd_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register access
	tmd_reg_if.bank rif
);
	logic cpu_en;
	logic panel_en;
	// A literal cannot be bit-selected, so the reset byte is held as a constant first.
	localparam logic [7:0] PROG_EN_RESET = `TMD_PROG_EN_RESET;

	// -------------------------------------------------------------------------
	// Storage
	// -------------------------------------------------------------------------
	// Any write outside the enable byte, and any reserved bit, is dropped.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cpu_en <= PROG_EN_RESET[`TMD_BIT_CPU_EN];
			panel_en <= PROG_EN_RESET[`TMD_BIT_PANEL_EN];
		end else if (rif.we && rif.addr == `TMD_REG_PROG_EN) begin
			cpu_en <= rif.wdata[`TMD_BIT_CPU_EN];
			panel_en <= rif.wdata[`TMD_BIT_PANEL_EN];
		end
	end

	// -------------------------------------------------------------------------
	// Readback
	// -------------------------------------------------------------------------
	always_comb begin
		if (rif.addr == `TMD_REG_PROG_EN) begin
			rif.rdata = {`TMD_RSVD_BITS, cpu_en, panel_en};
		end else begin
			rif.rdata = `TMD_READ_ZERO;
		end
	end

	assign rif.cpu_en = cpu_en;
	assign rif.panel_en = panel_en;
endmodule : tmd_regs

`default_nettype wire

// ===== tmd_top.sv
// Serial-bus register slave plus hardware test-mode control for a clock generator.
// Assumes rst is held from power-up; only a new rst leaves test mode.
`timescale 1ns/1ps
`default_nettype none
`include "tmd_map.svh"

// How it works
// - Bytes 0x10 to 0x28 are reserved and control nothing.
// - Bit 1 of byte 0x29 enables processor divider programming, reset zero.
// - Bit 0 of byte 0x29 enables panel divider programming, reset zero.
// - Test mode entered only when test-select is high at power-up; else outputs normal.
// - Test mode, once entered, holds until power is cycled.
// - In test mode, mode pin low floats outputs; high drives reference over divider.
// - The test-mode pin is followed in real time, never latched.
module tmd_top import tmd_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = `TMD_DEV_ADDR
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Serial management bus pins
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe,
	// Test pins
	input wire logic test_select_pin,
	input wire logic test_mode_pin,
	// Divider programming enables
	output logic cpu_divider_program_enable,
	output logic panel_divider_program_enable,
	// Clock output control
	output logic clk_out_enable,
	output logic clk_out_ref_div_sel,
	output logic test_mode_active
);
	tmd_reg_if rif();

	tmd_regs u_regs (
		.mclk(mclk),
		.rst(rst),
		.rif(rif)
	);

	// -------------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------------
	logic scl_meta, scl_s, scl_d;
	logic sda_meta, sda_s, sda_d;
	logic tsel_meta, tsel_s;
	logic tmode_meta, tmode_s;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_meta <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_meta <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_meta <= smb_clk;
			scl_s <= scl_meta;
			scl_d <= scl_s;
			sda_meta <= smb_data_in;
			sda_s <= sda_meta;
			sda_d <= sda_s;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tsel_meta <= 1'b0;
			tsel_s <= 1'b0;
			tmode_meta <= 1'b0;
			tmode_s <= 1'b0;
		end else begin
			tsel_meta <= test_select_pin;
			tsel_s <= tsel_meta;
			tmode_meta <= test_mode_pin;
			tmode_s <= tmode_meta;
		end
	end

	// -------------------------------------------------------------------------
	// Test mode
	// -------------------------------------------------------------------------
	// The select pin is caught once, after the synchroniser has filled with
	// post-reset samples, so a stale reset value is never mistaken for a strap.
	logic [1:0] settle_cnt;
	logic strap_done;
	logic test_latched;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			settle_cnt <= 2'h0;
			strap_done <= 1'b0;
			test_latched <= 1'b0;
		end else if (!strap_done) begin
			if (settle_cnt == `TMD_SETTLE_CYC) begin
				strap_done <= 1'b1;
				test_latched <= tsel_s;
			end else begin
				settle_cnt <= settle_cnt + 2'h1;
			end
		end
	end
	// Nothing but rst touches test_latched after capture.

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clk_out_enable <= 1'b1;
			clk_out_ref_div_sel <= 1'b0;
		end else if (!test_latched) begin
			clk_out_enable <= 1'b1;
			clk_out_ref_div_sel <= 1'b0;
		end else begin
			clk_out_enable <= tmode_s;
			clk_out_ref_div_sel <= tmode_s;
		end
	end

	assign test_mode_active = test_latched;

	// -------------------------------------------------------------------------
	// Serial slave
	// -------------------------------------------------------------------------
	tmd_state_t state;
	tmd_state_t after_ack;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic [7:0] ptr;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_stb;
	logic host_ack;
	logic start_det, stop_det, scl_rise, scl_fall;

	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det = scl_s && scl_d && !sda_d && sda_s;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= TMD_ST_IDLE;
			after_ack <= TMD_ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			txreg <= 8'h00;
			ptr <= 8'h00;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			wr_stb <= 1'b0;
			host_ack <= 1'b0;
			smb_data_oe <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (start_det) begin
				state <= TMD_ST_ADDR;
				bit_cnt <= 4'h0;
				smb_data_oe <= 1'b0;
			end else if (stop_det) begin
				state <= TMD_ST_IDLE;
				smb_data_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					TMD_ST_ADDR, TMD_ST_CMD, TMD_ST_WDATA: begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					TMD_ST_RACK: begin
						host_ack <= !sda_s;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					TMD_ST_ADDR: begin
						if (bit_cnt == `TMD_BITS_PER_BYTE) begin
							if (shreg[7:1] == DEV_ADDR) begin
								smb_data_oe <= 1'b1;
								after_ack <= shreg[0] ? TMD_ST_TX : TMD_ST_CMD;
								state <= TMD_ST_ACK;
							end else begin
								state <= TMD_ST_IDLE;
							end
						end
					end
					TMD_ST_CMD: begin
						if (bit_cnt == `TMD_BITS_PER_BYTE) begin
							ptr <= shreg;
							smb_data_oe <= 1'b1;
							after_ack <= TMD_ST_WDATA;
							state <= TMD_ST_ACK;
						end
					end
					TMD_ST_WDATA: begin
						if (bit_cnt == `TMD_BITS_PER_BYTE) begin
							wr_addr <= ptr;
							wr_data <= shreg;
							wr_stb <= 1'b1;
							ptr <= ptr + 8'h01;
							smb_data_oe <= 1'b1;
							after_ack <= TMD_ST_WDATA;
							state <= TMD_ST_ACK;
						end
					end
					TMD_ST_ACK: begin
						bit_cnt <= 4'h0;
						state <= after_ack;
						if (after_ack == TMD_ST_TX) begin
							txreg <= rif.rdata;
							smb_data_oe <= !rif.rdata[7];
							ptr <= ptr + 8'h01;
						end else begin
							smb_data_oe <= 1'b0;
						end
					end
					TMD_ST_TX: begin
						if (bit_cnt == `TMD_LAST_TX_BIT) begin
							smb_data_oe <= 1'b0;
							state <= TMD_ST_RACK;
						end else begin
							smb_data_oe <= !txreg[6];
							txreg <= {txreg[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					TMD_ST_RACK: begin
						bit_cnt <= 4'h0;
						if (host_ack) begin
							txreg <= rif.rdata;
							smb_data_oe <= !rif.rdata[7];
							ptr <= ptr + 8'h01;
							state <= TMD_ST_TX;
						end else begin
							state <= TMD_ST_IDLE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Open-drain data: only ever pulls low.
	assign smb_data_out = 1'b0;

	// -------------------------------------------------------------------------
	// Register bank hookup
	// -------------------------------------------------------------------------
	assign rif.addr = wr_stb ? wr_addr : ptr;
	assign rif.wdata = wr_data;
	assign rif.we = wr_stb;
	assign cpu_divider_program_enable = rif.cpu_en;
	assign panel_divider_program_enable = rif.panel_en;
endmodule : tmd_top

`default_nettype wire

// ===== tmd_top_chk.sv
// Checker for the test-mode control and enable bits of the bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module tmd_top_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Pins and outputs watched
	input wire logic test_select_pin,
	input wire logic test_mode_pin,
	input wire logic cpu_divider_program_enable,
	input wire logic panel_divider_program_enable,
	input wire logic clk_out_enable,
	input wire logic clk_out_ref_div_sel,
	input wire logic test_mode_active
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_norm;
		!test_mode_active |-> clk_out_enable && !clk_out_ref_div_sel;
	endproperty
	a_norm: assert property (p_norm) else $error("outputs not normal");
	property p_entry;
		$rose(test_mode_active) |-> $past(test_select_pin, 3);
	endproperty
	a_entry: assert property (p_entry) else $error("test entry without strap");
	property p_hold;
		test_mode_active |=> test_mode_active;
	endproperty
	a_hold: assert property (p_hold) else $error("test mode left");
	property p_hiz;
		(test_mode_active && !test_mode_pin) [*5] |-> !clk_out_enable;
	endproperty
	a_hiz: assert property (p_hiz) else $error("outputs not floated");
	property p_refdiv;
		(test_mode_active && test_mode_pin) [*5] |-> clk_out_enable && clk_out_ref_div_sel;
	endproperty
	a_refdiv: assert property (p_refdiv) else $error("reference not driven");
	property p_follow;
		test_mode_active && $fell(test_mode_pin) |-> ##[1:5] !clk_out_enable;
	endproperty
	a_follow: assert property (p_follow) else $error("mode pin not followed");
	property p_cpu_rst;
		$fell(rst) |-> !cpu_divider_program_enable;
	endproperty
	a_cpu_rst: assert property (p_cpu_rst) else $error("cpu enable not cleared");
	property p_pan_rst;
		$fell(rst) |-> !panel_divider_program_enable;
	endproperty
	a_pan_rst: assert property (p_pan_rst) else $error("panel enable not cleared");
endmodule : tmd_top_chk

bind tmd_top tmd_top_chk u_chk (.mclk, .rst, .test_select_pin, .test_mode_pin, .cpu_divider_program_enable,
	.panel_divider_program_enable, .clk_out_enable, .clk_out_ref_div_sel, .test_mode_active);

`default_nettype wire
